// *** shared/pss_pkg.sv ***
// Constants and types shared by both ends of the paged-register serial link.
// Assumes a host that makes the link clock and a device clocked by it.
// What this block does
// - Every field is shifted most significant bit first.
// - Host sends direction, then page, then register.
// - Direction 0 reads, direction 1 writes.
// - Flag after address: 0 single, 1 burst.
// - Four idle bit times, then 8-bit data bytes.
// - Serial output is meaningless during write frames.
// - Read fetch during idle bits, data right after.
// - Single access touches exactly one register.
// - Burst lasts while chip select stays high.
// - Burst address steps by one per byte.
// - Partial final byte is discarded, never applied.
// - Chip select opens and closes each frame.
// - Serial output driven only while returning read data.
package pss_pkg;
    localparam int PAGE_W = 3;
    localparam int ADDR_W = 8;
    localparam int BYTE_W = 8;
    localparam int UNUSED_BITS = 4;
    localparam int HDR_BITS = 1 + PAGE_W + ADDR_W + 1;
    localparam int DATA_START = HDR_BITS + UNUSED_BITS;
    localparam int CNT_W = 5;
    localparam int LEN_W = 8;
    localparam logic DIR_READ = 1'h0;
    localparam logic DIR_WRITE = 1'h1;
    localparam logic ACC_BURST = 1'h1;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SCK_HALF_NS = 25;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DIV_W = 8;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [3:0] {
        PSS_IDLE = 4'h1,
        PSS_HEAD = 4'h2,
        PSS_FETCH = 4'h4,
        PSS_DATA = 4'h8
    } pss_host_state_t;
endpackage

// *** shared/pss_link_if.sv ***
// Four-wire serial link between the host end and the device end.
// Assumes the bench instantiates it once per link and ties the ends of that link to it.
`timescale 1ns/1ps
`default_nettype none
interface pss_link_if;
    logic sck;
    logic host_chip_select;
    logic mosi;
    logic sdo_out;
    logic sdo_oe;
    logic sdo_line;

    // The output line idles high when the device does not drive it.
    assign sdo_line = sdo_oe ? sdo_out : 1'h1;

    modport device (input sck, input host_chip_select, input mosi,
                    output sdo_out, output sdo_oe);
    modport host (output sck, output host_chip_select, output mosi, input sdo_line);
endinterface
`default_nettype wire

// *** verilog/pss_device_end.sv ***
// Device end: serial frame decoder on the link clock, register port on clock.
// Assumes the register file answers a read strobe with data one cycle later.
`timescale 1ns/1ps
`default_nettype none
module pss_device_end #(
    parameter int PAGE_W = pss_pkg::PAGE_W,
    parameter int ADDR_W = pss_pkg::ADDR_W
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic ce,
    pss_link_if.device link,
    output logic reg_wr,
    output logic reg_rd,
    output logic [PAGE_W-1:0] reg_page,
    output logic [ADDR_W-1:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    localparam int HB = 1 + PAGE_W + ADDR_W + 1;
    localparam int DS = HB + pss_pkg::UNUSED_BITS;
    localparam int CW = pss_pkg::CNT_W;

    // Frame state, cleared whenever chip select is low.
    typedef struct packed {
        logic [HB-1:0] hdr;
        logic [CW-1:0] cnt;
        logic in_data;
        logic [2:0] bit_idx;
        logic [6:0] rx;
        logic [ADDR_W-1:0] addr;
        logic done;
    } pss_frame_t;

    // Hand-off words toward the clock domain; they survive frame ends.
    typedef struct packed {
        logic wr_tgl;
        logic [PAGE_W-1:0] wr_page;
        logic [ADDR_W-1:0] wr_addr;
        logic [7:0] wr_data;
        logic rd_tgl;
        logic [PAGE_W-1:0] rd_page;
        logic [ADDR_W-1:0] rd_addr;
    } pss_xfer_t;

    // Output shifter on the falling link clock edge.
    typedef struct packed {
        logic [7:0] tx;
        logic oe;
    } pss_drive_t;

    // Register port side on the system clock.
    typedef struct packed {
        logic wr_s1;
        logic wr_s2;
        logic wr_seen;
        logic rd_s1;
        logic rd_s2;
        logic rd_seen;
        logic wr;
        logic rd;
        logic [PAGE_W-1:0] page;
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic cap;
        logic [7:0] rd_hold;
    } pss_core_t;

    pss_frame_t f_reg;
    pss_frame_t f_next;
    pss_xfer_t x_reg;
    pss_xfer_t x_next;
    pss_drive_t d_reg;
    pss_drive_t d_next;
    pss_core_t c_reg;
    pss_core_t c_next;
    logic frame_rst_n;
    logic [HB-1:0] hdr_full;
    logic f_rw;
    logic f_burst;

    function automatic logic [PAGE_W-1:0] hdr_page(input logic [HB-1:0] h);
        hdr_page = h[HB-2 -: PAGE_W];
    endfunction

    function automatic logic [ADDR_W-1:0] hdr_addr(input logic [HB-1:0] h);
        hdr_addr = h[ADDR_W:1];
    endfunction

    // Chip select low holds the frame logic in reset.
    assign frame_rst_n = arst_n & link.host_chip_select;

    // Header bits arrive first, in order, most significant first.
    assign hdr_full = {f_reg.hdr[HB-2:0], link.mosi};
    assign f_rw = f_reg.hdr[HB-1];
    assign f_burst = f_reg.hdr[0];

    always_comb begin
        f_next = f_reg;
        x_next = x_reg;
        if (!f_reg.in_data) begin
            f_next.cnt = CW'(f_reg.cnt + 1'h1);
            if (f_reg.cnt < CW'(HB)) begin
                f_next.hdr = hdr_full;
            end
            if (f_reg.cnt == CW'(HB - 1)) begin
                f_next.addr = hdr_addr(hdr_full);
                // A read fetch starts while the idle bits go by.
                if (hdr_full[HB-1] == pss_pkg::DIR_READ) begin
                    x_next.rd_tgl = ~x_reg.rd_tgl;
                    x_next.rd_page = hdr_page(hdr_full);
                    x_next.rd_addr = hdr_addr(hdr_full);
                end
            end
            if (f_reg.cnt == CW'(DS - 1)) begin
                f_next.in_data = 1'h1;
            end
        end else if (!f_reg.done) begin
            f_next.bit_idx = f_reg.bit_idx + 3'h1;
            f_next.rx = {f_reg.rx[5:0], link.mosi};
            // A burst read prefetches the next register at each byte start.
            if (f_rw == pss_pkg::DIR_READ && f_burst == pss_pkg::ACC_BURST
                && f_reg.bit_idx == 3'h0) begin
                f_next.addr = f_reg.addr + 1'h1;
                x_next.rd_tgl = ~x_reg.rd_tgl;
                x_next.rd_page = hdr_page(f_reg.hdr);
                x_next.rd_addr = f_reg.addr + 1'h1;
            end
            // Only a complete byte is handed over for writing.
            if (f_reg.bit_idx == 3'h7) begin
                if (f_rw == pss_pkg::DIR_WRITE) begin
                    x_next.wr_tgl = ~x_reg.wr_tgl;
                    x_next.wr_page = hdr_page(f_reg.hdr);
                    x_next.wr_addr = f_reg.addr;
                    x_next.wr_data = {f_reg.rx, link.mosi};
                    if (f_burst == pss_pkg::ACC_BURST) begin
                        f_next.addr = f_reg.addr + 1'h1;
                    end
                end
                if (f_burst != pss_pkg::ACC_BURST) begin
                    f_next.done = 1'h1;
                end
            end
        end
    end

    // Input sampling on the rising link clock edge.
    always_ff @(posedge link.sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            f_reg <= '0;
        end else begin
            f_reg <= f_next;
        end
    end

    always_ff @(posedge link.sck or negedge arst_n) begin
        if (!arst_n) begin
            x_reg <= '0;
        end else begin
            x_reg <= x_next;
        end
    end

    // The fetched byte has been stable for several bit times when loaded.
    always_comb begin
        d_next = d_reg;
        if (f_reg.in_data && !f_reg.done && f_rw == pss_pkg::DIR_READ) begin
            d_next.oe = 1'h1;
            if (f_reg.bit_idx == 3'h0) begin
                d_next.tx = c_reg.rd_hold;
            end else begin
                d_next.tx = {d_reg.tx[6:0], 1'h0};
            end
        end else begin
            d_next.oe = 1'h0;
        end
    end

    // Output changes on the falling link clock edge.
    always_ff @(negedge link.sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            d_reg <= '0;
        end else begin
            d_reg <= d_next;
        end
    end

    assign link.sdo_out = d_reg.tx[7];
    assign link.sdo_oe = d_reg.oe;

    // Toggles cross by two flip-flops; their words are held meanwhile.
    always_comb begin
        c_next = c_reg;
        c_next.wr_s1 = x_reg.wr_tgl;
        c_next.wr_s2 = c_reg.wr_s1;
        c_next.rd_s1 = x_reg.rd_tgl;
        c_next.rd_s2 = c_reg.rd_s1;
        c_next.wr = 1'h0;
        c_next.rd = 1'h0;
        c_next.cap = c_reg.rd;
        if (c_reg.cap) begin
            c_next.rd_hold = reg_rdata;
        end
        if (c_reg.wr_s2 != c_reg.wr_seen) begin
            c_next.wr_seen = c_reg.wr_s2;
            c_next.wr = 1'h1;
            c_next.page = x_reg.wr_page;
            c_next.addr = x_reg.wr_addr;
            c_next.wdata = x_reg.wr_data;
        end else if (c_reg.rd_s2 != c_reg.rd_seen) begin
            c_next.rd_seen = c_reg.rd_s2;
            c_next.rd = 1'h1;
            c_next.page = x_reg.rd_page;
            c_next.addr = x_reg.rd_addr;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            c_reg <= '0;
        end else if (ce) begin
            c_reg <= c_next;
        end
    end

    assign reg_wr = c_reg.wr;
    assign reg_rd = c_reg.rd;
    assign reg_page = c_reg.page;
    assign reg_addr = c_reg.addr;
    assign reg_wdata = c_reg.wdata;
endmodule
`default_nettype wire

// *** verilog/pss_host_end.sv ***
// Host end: frame sequencer with a write-data FIFO, making the link clock.
// Assumes a user that pushes write bytes and takes read bytes at once.
`timescale 1ns/1ps
`default_nettype none
module pss_fifo #(
    parameter int W = 8,
    parameter int D = pss_pkg::FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [AW:0] cnt_reg;
    logic ready_reg;
    logic push;
    logic pop;

    // Ready comes from a flip-flop so that the write-byte port answers from state.
    assign in_ready = ready_reg;
    assign out_valid = cnt_reg != '0;
    assign out_data = mem[rp_reg];
    assign push = ce & in_valid & in_ready;
    assign pop = ce & out_ready & out_valid;

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wp_reg] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
            ready_reg <= 1'h0;
        end else begin
            if (push) begin
                wp_reg <= (wp_reg == AW'(D - 1)) ? '0 : AW'(wp_reg + 1'h1);
            end
            if (pop) begin
                rp_reg <= (rp_reg == AW'(D - 1)) ? '0 : AW'(rp_reg + 1'h1);
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 1'h1;
                ready_reg <= cnt_reg != (AW+1)'(D - 1);
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 1'h1;
                ready_reg <= 1'h1;
            end else if (ce) begin
                ready_reg <= cnt_reg != (AW+1)'(D);
            end
        end
    end
endmodule

module pss_host_end #(
    parameter int HALF = pss_pkg::SCK_HALF_CYC
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic ce,
    pss_link_if.host link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_rw,
    input wire logic [pss_pkg::PAGE_W-1:0] cmd_page,
    input wire logic [pss_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic cmd_burst,
    input wire logic [pss_pkg::LEN_W-1:0] cmd_len,
    input wire logic wdata_valid,
    output logic wdata_ready,
    input wire logic [7:0] wdata,
    output logic rdata_valid,
    output logic [7:0] rdata
);
    localparam int DS = pss_pkg::DATA_START;

    typedef struct packed {
        pss_pkg::pss_host_state_t st;
        logic [pss_pkg::DIV_W-1:0] div;
        logic sck;
        logic cs;
        logic mosi;
        logic [DS-1:0] sh;
        logic [pss_pkg::CNT_W-1:0] bits;
        logic [pss_pkg::LEN_W-1:0] left;
        logic rw;
        logic [7:0] rx;
        logic rx_valid;
        logic [7:0] rx_data;
        logic s1;
        logic s2;
        logic cmd_ready;
    } pss_host_t;

    pss_host_t h_reg;
    pss_host_t h_next;
    logic f_valid;
    logic f_ready;
    logic [7:0] f_data;

    pss_fifo #(.W(8), .D(pss_pkg::FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .arst_n(arst_n),
        .ce(ce),
        .in_valid(wdata_valid),
        .in_ready(wdata_ready),
        .in_data(wdata),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    assign f_ready = (h_reg.st == pss_pkg::PSS_FETCH);

    always_comb begin
        h_next = h_reg;
        h_next.s1 = link.sdo_line;
        h_next.s2 = h_reg.s1;
        h_next.rx_valid = 1'h0;
        unique case (h_reg.st)
            pss_pkg::PSS_IDLE: begin
                h_next.cmd_ready = 1'h1;
                if (cmd_valid && h_reg.cmd_ready) begin
                    h_next.cmd_ready = 1'h0;
                    h_next.cs = 1'h1;
                    h_next.rw = cmd_rw;
                    h_next.mosi = cmd_rw;
                    h_next.sh = {cmd_page, cmd_addr, cmd_burst, 5'h00};
                    h_next.bits = pss_pkg::CNT_W'(DS);
                    h_next.left = (cmd_burst && cmd_len != '0) ? cmd_len : 8'h01;
                    h_next.div = '0;
                    h_next.st = pss_pkg::PSS_HEAD;
                end
            end
            pss_pkg::PSS_FETCH: begin
                if (f_valid) begin
                    h_next.mosi = f_data[7];
                    h_next.sh = {f_data[6:0], (DS-7)'(0)};
                    h_next.bits = 5'h08;
                    h_next.div = '0;
                    h_next.st = pss_pkg::PSS_DATA;
                end
            end
            pss_pkg::PSS_HEAD, pss_pkg::PSS_DATA: begin
                h_next.div = h_reg.div + 1'h1;
                if (h_reg.div == pss_pkg::DIV_W'(HALF - 1)) begin
                    h_next.div = '0;
                    h_next.sck = ~h_reg.sck;
                    if (!h_reg.sck) begin
                        h_next.rx = {h_reg.rx[6:0], h_reg.s2};
                    end else begin
                        h_next.bits = h_reg.bits - 1'h1;
                        h_next.mosi = h_reg.sh[DS-1];
                        h_next.sh = {h_reg.sh[DS-2:0], 1'h0};
                        if (h_reg.bits == 5'h01) begin
                            if (h_reg.st == pss_pkg::PSS_DATA) begin
                                h_next.left = h_reg.left - 1'h1;
                                h_next.rx_valid = (h_reg.rw == pss_pkg::DIR_READ);
                                h_next.rx_data = h_reg.rx;
                            end
                            // Chip select drops only on a byte boundary.
                            if (h_reg.st == pss_pkg::PSS_DATA && h_reg.left == 8'h01) begin
                                h_next.cs = 1'h0;
                                h_next.st = pss_pkg::PSS_IDLE;
                            end else if (h_reg.rw == pss_pkg::DIR_WRITE) begin
                                h_next.st = pss_pkg::PSS_FETCH;
                            end else begin
                                h_next.mosi = 1'h0;
                                h_next.bits = 5'h08;
                                h_next.st = pss_pkg::PSS_DATA;
                            end
                        end
                    end
                end
            end
            default: begin
                h_next.st = pss_pkg::PSS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            h_reg <= '0;
            h_reg.st <= pss_pkg::PSS_IDLE;
        end else if (ce) begin
            h_reg <= h_next;
        end
    end

    assign link.sck = h_reg.sck;
    assign link.host_chip_select = h_reg.cs;
    assign link.mosi = h_reg.mosi;
    assign cmd_ready = h_reg.cmd_ready;
    assign rdata_valid = h_reg.rx_valid;
    assign rdata = h_reg.rx_data;
endmodule
`default_nettype wire

// *** sim/pss_link_props.sv ***
// Checker for the serial link that joins the host end and the device end.
// Assumes the bench instantiates it beside the link and feeds it the link signals.
`timescale 1ns/1ps
`default_nettype none
module pss_link_props (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic sck,
    input wire logic host_chip_select,
    input wire logic mosi,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    input wire logic sdo_line
);
    logic sck_q;
    logic [11:0] rises;
    logic dir_wr;

    // Counts rising link clock edges within a frame and keeps the direction bit.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sck_q <= 1'h0;
            rises <= 12'h000;
            dir_wr <= 1'h0;
        end else begin
            sck_q <= sck;
            if (!host_chip_select) begin
                rises <= 12'h000;
            end else if (sck && !sck_q) begin
                rises <= rises + 12'h001;
                if (rises == 12'h000) begin
                    dir_wr <= mosi;
                end
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    idle_clock_low_a: assert property (!host_chip_select |-> !sck)
        else $error("link clock active outside a frame");
    out_released_a: assert property (!host_chip_select && $past(!host_chip_select) |-> !sdo_oe)
        else $error("serial output driven without a frame");
    write_quiet_a: assert property (host_chip_select && dir_wr && rises != 12'h000
        |-> !sdo_oe && sdo_line) else $error("serial output driven in a write frame");
    fetch_quiet_a: assert property (host_chip_select && rises < 12'h011 |-> !sdo_oe)
        else $error("serial output driven before the data bytes");
    read_drive_a: assert property (host_chip_select && !dir_wr && rises >= 12'h012
        && rises <= 12'h018 |-> sdo_oe) else $error("read data not driven");
    unused_zero_a: assert property (sck && !sck_q && rises >= 12'h00D && rises <= 12'h010
        |-> !mosi) else $error("unused bit not zero");
    byte_end_a: assert property ($fell(host_chip_select)
        |-> rises >= 12'h019 && rises[2:0] == 3'h1) else $error("frame ended off a byte");
    mosi_low_change_a: assert property ($changed(mosi) |-> !sck)
        else $error("host data changed while link clock high");
    sdo_low_change_a: assert property (sdo_oe && $changed(sdo_out) |-> !sck)
        else $error("device data changed while link clock high");
    clock_high_width_a: assert property ($rose(sck) |-> sck[*5] ##1 !sck)
        else $error("link clock high phase has wrong length");
endmodule
`default_nettype wire

// *** sim/pmic_spi_slave_access_tb.sv ***
// Testbench joining the host end and the device end through the link.
// Assumes the package, the link, both ends and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module pmic_spi_slave_access_tb;
    logic clock = 1'h0;
    logic arst_n = 1'h0;
    logic cmd_valid = 1'h0, cmd_rw = 1'h0, cmd_burst = 1'h0, wdata_valid = 1'h0;
    logic [2:0] cmd_page = 3'h0;
    logic [7:0] cmd_addr = 8'h00, cmd_len = 8'h00, wdata = 8'h00, reg_rdata = 8'h00;
    logic cmd_ready, wdata_ready, rdata_valid, reg_wr, reg_rd, reg_wr2;
    logic [2:0] reg_page, reg_page2;
    logic [7:0] rdata, reg_addr, reg_wdata, reg_addr2, reg_wdata2;
    int fails = 0;
    int n_compared = 0;
    int nb = 0;
    logic [31:0] seed = 32'h00017802;
    logic [7:0] mem [0:2047];
    logic [7:0] shadow [0:2047];
    logic [18:0] wr_q[$], wr2_q[$];
    logic [7:0] rd_q[$];
    logic [16:0] hdr = 17'h00000, exp_hdr = 17'h00000;

    pss_link_if link();
    pss_link_if link2();
    pss_host_end pss_host_end_i (.clock(clock), .arst_n(arst_n), .ce(1'h1), .link(link),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_rw(cmd_rw), .cmd_page(cmd_page),
        .cmd_addr(cmd_addr), .cmd_burst(cmd_burst), .cmd_len(cmd_len),
        .wdata_valid(wdata_valid), .wdata_ready(wdata_ready), .wdata(wdata),
        .rdata_valid(rdata_valid), .rdata(rdata));
    pss_device_end pss_device_end_i (.clock(clock), .arst_n(arst_n), .ce(1'h1), .link(link),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_page(reg_page), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    pss_device_end pss_device_end_i2 (.clock(clock), .arst_n(arst_n), .ce(1'h1), .link(link2),
        .reg_wr(reg_wr2), .reg_rd(), .reg_page(reg_page2), .reg_addr(reg_addr2),
        .reg_wdata(reg_wdata2), .reg_rdata(8'h00));
    pss_link_props pss_link_props_i (.clock(clock), .arst_n(arst_n), .sck(link.sck),
        .host_chip_select(link.host_chip_select), .mosi(link.mosi), .sdo_out(link.sdo_out),
        .sdo_oe(link.sdo_oe), .sdo_line(link.sdo_line));

    initial begin
        forever #2.5 clock = ~clock;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [18:0] seen, input logic [18:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (fails == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic cmd(input logic rw, input logic [2:0] pg, input logic [7:0] ad,
                       input logic bu, input logic [7:0] len);
        int t;
        @(negedge clock);
        cmd_valid = 1'h1;
        cmd_rw = rw;
        cmd_page = pg;
        cmd_addr = ad;
        cmd_burst = bu;
        cmd_len = len;
        for (t = 0; t < 1000 && cmd_ready !== 1'h1; t++) @(negedge clock);
        @(negedge clock);
        cmd_valid = 1'h0;
        for (t = 0; t < 40000 && cmd_ready !== 1'h1; t++) @(negedge clock);
        if (t == 40000) fails++;
    endtask

    task automatic push(input logic [7:0] d);
        @(negedge clock);
        wdata_valid = 1'h1;
        wdata = d;
        while (wdata_ready !== 1'h1) @(negedge clock);
        @(negedge clock);
        wdata_valid = 1'h0;
    endtask

    // Notes the expected results of one frame, then runs it; late delays the write bytes.
    task automatic xfer(input logic rw, input logic [2:0] pg, input logic [7:0] ad,
                        input logic bu, input int n, input int late);
        logic [7:0] b[$];
        exp_hdr = {rw, pg, ad, bu, 4'h0};
        for (int i = 0; i < n; i++) begin
            b.push_back(8'(rnd()));
            if (rw) begin
                shadow[{pg, ad + 8'(i)}] = b[i];
                wr_q.push_back({pg, ad + 8'(i), b[i]});
            end else begin
                rd_q.push_back(shadow[{pg, ad + 8'(i)}]);
            end
        end
        if (rw && late == 0) begin
            foreach (b[k]) push(b[k]);
            if (n == 16) check(19'(wdata_ready), 19'h00000);
        end
        fork
            cmd(rw, pg, ad, bu, 8'(n));
            if (rw && late != 0) begin
                repeat (late) @(negedge clock);
                foreach (b[k]) push(b[k]);
            end
        join
    endtask

    // Drives the second link by hand; nbits counts from the first bit of the frame.
    task automatic frame2(input logic [24:0] f, input int nbits);
        link2.host_chip_select = 1'h1;
        #24;
        for (int i = 24; i > 24 - nbits; i--) begin
            link2.mosi = f[i];
            #24 link2.sck = 1'h1;
            #24 link2.sck = 1'h0;
        end
        #24 link2.host_chip_select = 1'h0;
        #96;
    endtask

    // Register file of the device end, and the watcher of register writes, read bytes and second-link writes.
    always @(negedge clock) begin
        if (reg_rd === 1'h1) reg_rdata = mem[{reg_page, reg_addr}];
        if (reg_wr === 1'h1) begin
            mem[{reg_page, reg_addr}] = reg_wdata;
            check({reg_page, reg_addr, reg_wdata}, wr_q.size() ? wr_q.pop_front() : 19'hX);
        end
        if (rdata_valid === 1'h1) check(rdata, rd_q.size() ? rd_q.pop_front() : 19'hX);
        if (reg_wr2 === 1'h1) check({reg_page2, reg_addr2, reg_wdata2}, wr2_q.size() ? wr2_q.pop_front() : 19'hX);
    end

    always @(posedge link.host_chip_select) nb = 0;
    always @(posedge link.sck) begin
        if (link.host_chip_select && nb < 17) begin
            hdr = {hdr[15:0], link.mosi};
            nb++;
        end
    end
    always @(negedge link.host_chip_select) if (arst_n) check(hdr, exp_hdr);

    initial begin
        logic [2:0] pg;
        logic [7:0] ad;
        link2.sck = 1'h0;
        link2.host_chip_select = 1'h0;
        link2.mosi = 1'h0;
        for (int i = 0; i < 2048; i++) begin
            mem[i] = 8'(rnd());
            shadow[i] = mem[i];
        end
        repeat (10) @(negedge clock);
        arst_n = 1'h1;
        repeat (3) @(negedge clock);
        for (int i = 0; i < 4; i++) begin
            pg = 3'(rnd());
            ad = 8'(rnd());
            xfer(1'h1, pg, ad, 1'h0, 1, 0);
            xfer(1'h0, pg, ad, 1'h0, 1, 0);
            xfer(1'h0, pg, ad + 8'h01, 1'h0, 1, 0);
        end
        for (int n = 2; n <= 16; n += 7) begin
            pg = 3'(rnd());
            ad = 8'(rnd() % 200);
            xfer(1'h1, pg, ad, 1'h1, n, 0);
            xfer(1'h0, pg, ad, 1'h1, n, 0);
        end
        xfer(1'h1, 3'h2, 8'h10, 1'h1, 3, 40);
        xfer(1'h0, 3'h2, 8'h10, 1'h1, 3, 0);
        frame2({1'h1, 3'h5, 8'h33, 1'h0, 4'h0, 8'hA5}, 22);
        wr2_q.push_back({3'h5, 8'h34, 8'h5A});
        frame2({1'h1, 3'h5, 8'h34, 1'h0, 4'h0, 8'h5A}, 25);
        repeat (20) @(negedge clock);
        check(19'(wr_q.size() + rd_q.size() + wr2_q.size()), 19'h00000);
        tally_and_finish();
    end

    initial begin
        #400000;
        fails++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
